/* src/cdac_ctrl.sv */
// Current converter control and status block with AXI4-Lite register slave
//
// Function
// - Bus output enable: software bit or event
// - Pad and bus enables gated independently
// - Master disable stops mastering selected bus
// - Master disabled: passive, own request ignored
// - Control bit 2 enables minimum transition
// - Software enable pauses node charge/discharge
// - Trim field bits 23:16, reset 0x9B
// - Step field bits 12:8 sets step
// - Range field bits 1:0, reset 0
// - Status bit 0 shows current settled
// - Status bit 1 shows bus conflict
// - Flag bit 1 latches bus conflict
// - Flag bit 0 set on settled rise
// - Flag-set register writes ones set flags
// - Flag-clear writes clear; read returns, clears
`timescale 1ns/1ps
`include "cdac_regs.svh"
module cdac_ctrl
    import cdac_pkg::*;
#(
    parameter int EVENT_CHANNELS = 12,
    parameter int SETTLE_CYCLES  = (`CDAC_SETTLE_NS + `CDAC_CLK_NS - 1) / `CDAC_CLK_NS
)
(
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // AXI4-Lite slave
    input  wire logic [5:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [5:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // System side
    input  wire logic [EVENT_CHANNELS-1:0] eventChannels,
    input  wire logic [7:0]                busSelectExternal,
    input  wire logic                      busRequestOther,
    output logic                           converterEnable,
    output logic                           sinkSelect,
    output logic [1:0]                     rangeSelect,
    output logic [4:0]                     stepSelect,
    output logic [7:0]                     trimValue,
    output logic                           dutyCycleDisable,
    output logic                           busOutEnable,
    output logic                           padOutEnable,
    output logic                           busMaster,
    output logic [7:0]                     busChannel,
    output logic                           busRequest,
    output logic                           nodePrecharge,
    output logic                           irq
);
    logic [31:0] ctrl_r;
    logic [31:0] curProg_r;
    logic [31:0] duty_r;
    cdac_flags_t flags_r;
    cdac_flags_t ien_r;
    cdac_wr_e    wrState_r;
    logic        awHeld_r;
    logic        wHeld_r;
    logic [5:0]  awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        settled;
    logic        settled_r;
    logic        conflict;
    logic        conflict_r;
    logic        progChange;
    logic        doWrite;
    logic        wrHit;
    logic        doRead;
    logic        rdClear;
    logic [31:0] wrMask;
    cdac_flags_t setReq;
    cdac_flags_t clrReq;
    logic [31:0] rdData;
    logic        rdHit;

    // Write channel: take address and data in either order, answer after both
    assign s_axi_awready = (wrState_r == CDAC_WR_IDLE) && !awHeld_r;
    assign s_axi_wready  = (wrState_r == CDAC_WR_IDLE) && !wHeld_r;
    assign doWrite = (wrState_r == CDAC_WR_IDLE)
                     && (awHeld_r || s_axi_awvalid) && (wHeld_r || s_axi_wvalid);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wrState_r <= CDAC_WR_IDLE;
            awHeld_r  <= 1'b0;
            wHeld_r   <= 1'b0;
            awAddr_r  <= '0;
            wData_r   <= '0;
            wStrb_r   <= '0;
        end
        else
        begin
            case (wrState_r)
                CDAC_WR_IDLE:
                begin
                    if (s_axi_awvalid && !awHeld_r)
                    begin
                        awAddr_r <= s_axi_awaddr;
                        awHeld_r <= 1'b1;
                    end
                    if (s_axi_wvalid && !wHeld_r)
                    begin
                        wData_r <= s_axi_wdata;
                        wStrb_r <= s_axi_wstrb;
                        wHeld_r <= 1'b1;
                    end
                    if (doWrite)
                    begin
                        awHeld_r  <= 1'b0;
                        wHeld_r   <= 1'b0;
                        wrState_r <= CDAC_WR_RESP;
                    end
                end
                CDAC_WR_RESP:
                begin
                    if (s_axi_bready)
                        wrState_r <= CDAC_WR_IDLE;
                end
                default:
                    wrState_r <= CDAC_WR_IDLE;
            endcase
        end
    end

    assign s_axi_bvalid = (wrState_r == CDAC_WR_RESP);

    // Effective write address, data and byte mask for the cycle of the write
    logic [5:0]  wAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    assign wAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
    assign wData = wHeld_r ? wData_r : s_axi_wdata;
    assign wStrb = wHeld_r ? wStrb_r : s_axi_wstrb;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_lane
            assign wrMask[gb*8 +: 8] = {8{wStrb[gb]}};
        end
    endgenerate

    // Address decode for writes; unmapped or read-only offsets answer SLVERR
    always_comb
    begin
        wrHit = 1'b1;
        if (wAddr == `CDAC_OFF_CTRL)
            wrHit = 1'b1;
        else if (wAddr == `CDAC_OFF_CURPROG)
            wrHit = 1'b1;
        else if (wAddr == `CDAC_OFF_DUTY)
            wrHit = 1'b1;
        else if (wAddr == `CDAC_OFF_IFS)
            wrHit = 1'b1;
        else if (wAddr == `CDAC_OFF_IFC)
            wrHit = 1'b1;
        else if (wAddr == `CDAC_OFF_IEN)
            wrHit = 1'b1;
        else
            wrHit = 1'b0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            s_axi_bresp <= `CDAC_RESP_OKAY;
        else if (doWrite)
            s_axi_bresp <= wrHit ? `CDAC_RESP_OKAY : `CDAC_RESP_SLVERR;
    end

    // Control register; reserved bits never store, so they read zero
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ctrl_r <= '0;
        else if (doWrite && wAddr == `CDAC_OFF_CTRL)
            ctrl_r <= (ctrl_r & ~wrMask) | (wData & wrMask & `CDAC_CTRL_MASK);
    end

    // Current programming: trim resets to its calibrated middle value
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            curProg_r <= `CDAC_CUR_RESET;
        else if (doWrite && wAddr == `CDAC_OFF_CURPROG)
            curProg_r <= (curProg_r & ~wrMask) | (wData & wrMask & `CDAC_CUR_MASK);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            duty_r <= '0;
        else if (doWrite && wAddr == `CDAC_OFF_DUTY)
            duty_r <= (duty_r & ~wrMask) | (wData & wrMask & `CDAC_DUTY_MASK);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ien_r <= '0;
        else if (doWrite && wAddr == `CDAC_OFF_IEN && wStrb[0])
            ien_r <= wData[1:0];
    end

    // Field outputs to the analog core
    assign converterEnable  = ctrl_r[`CDAC_CTRL_EN];
    assign sinkSelect       = ctrl_r[`CDAC_CTRL_SINK];
    assign rangeSelect      = curProg_r[`CDAC_CUR_RANGE_HI:`CDAC_CUR_RANGE_LO];
    assign stepSelect       = curProg_r[`CDAC_CUR_STEP_HI:`CDAC_CUR_STEP_LO];
    assign trimValue        = curProg_r[`CDAC_CUR_TRIM_HI:`CDAC_CUR_TRIM_LO];
    assign dutyCycleDisable = duty_r[`CDAC_DUTY_DIS];

    // Bus and pad output enables, each with its own mode and soft bit, both using the one event select field
    cdac_event_select #(.CHANNELS(EVENT_CHANNELS)) u_busSel
    (
        .events   (eventChannels),
        .sel      (ctrl_r[`CDAC_CTRL_ESEL_HI:`CDAC_CTRL_ESEL_LO]),
        .prsCtrl  (ctrl_r[`CDAC_CTRL_BUSPRS]),
        .swEnable (ctrl_r[`CDAC_CTRL_BUSOUT]),
        .enable   (busOutEnable)
    );

    cdac_event_select #(.CHANNELS(EVENT_CHANNELS)) u_padSel
    (
        .events   (eventChannels),
        .sel      (ctrl_r[`CDAC_CTRL_ESEL_HI:`CDAC_CTRL_ESEL_LO]),
        .prsCtrl  (ctrl_r[`CDAC_CTRL_PADPRS]),
        .swEnable (ctrl_r[`CDAC_CTRL_PADOUT]),
        .enable   (padOutEnable)
    );

    // Mastering: passive observers follow the external selection
    assign busMaster  = !ctrl_r[`CDAC_CTRL_MASTDIS];
    assign busChannel = busMaster ? ctrl_r[`CDAC_CTRL_BSEL_HI:`CDAC_CTRL_BSEL_LO]
                                  : busSelectExternal;
    assign busRequest = busMaster && busOutEnable;

    // Precharge halts while a software enable is set; event-driven enables do not halt it
    assign nodePrecharge = ctrl_r[`CDAC_CTRL_MINTR]
                           && !ctrl_r[`CDAC_CTRL_BUSOUT]
                           && !ctrl_r[`CDAC_CTRL_PADOUT];

    // Any programming change restarts the settling wait
    assign progChange = doWrite && wAddr == `CDAC_OFF_CURPROG && (wStrb[0] || wStrb[1]
                        || wStrb[2]);

    cdac_settle_timer #(.CYCLES(SETTLE_CYCLES)) u_settle
    (
        .clk     (clk),
        .rstn    (rstn),
        .enable  (converterEnable),
        .restart (progChange),
        .settled (settled)
    );

    assign conflict = busRequest && busRequestOther;

    // Edge history for the flag sources
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            settled_r  <= 1'b0;
            conflict_r <= 1'b0;
        end
        else
        begin
            settled_r  <= settled;
            conflict_r <= conflict;
        end
    end

    // Read channel: one read at a time, data registered
    assign s_axi_arready = !s_axi_rvalid;
    assign doRead = s_axi_arvalid && s_axi_arready;
    assign rdClear = doRead && s_axi_araddr == `CDAC_OFF_IFC;

    // Flag set and clear requests; hardware and set-register sets win over clears
    always_comb
    begin
        setReq = '0;
        clrReq = '0;
        setReq[`CDAC_FLAG_SETTLED]  = settled && !settled_r;
        setReq[`CDAC_FLAG_CONFLICT] = conflict && !conflict_r;
        if (doWrite && wAddr == `CDAC_OFF_IFS && wStrb[0])
            setReq = setReq | (wData[1:0] & `CDAC_FLAG_MASK);
        if (doWrite && wAddr == `CDAC_OFF_IFC && wStrb[0])
            clrReq = wData[1:0] & `CDAC_FLAG_MASK;
        if (rdClear)
            clrReq = `CDAC_FLAG_MASK;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            flags_r <= '0;
        else
            flags_r <= (flags_r & ~clrReq) | setReq;
    end

    assign irq = |(flags_r & ien_r);

    // Read decode
    always_comb
    begin
        rdData = '0;
        rdHit  = 1'b1;
        if (s_axi_araddr == `CDAC_OFF_CTRL)
            rdData = ctrl_r;
        else if (s_axi_araddr == `CDAC_OFF_CURPROG)
            rdData = curProg_r;
        else if (s_axi_araddr == `CDAC_OFF_DUTY)
            rdData = duty_r;
        else if (s_axi_araddr == `CDAC_OFF_STATUS)
            rdData = {30'h0, conflict, settled};
        else if (s_axi_araddr == `CDAC_OFF_IF)
            rdData = {30'h0, flags_r};
        else if (s_axi_araddr == `CDAC_OFF_IFC)
            rdData = {30'h0, flags_r};
        else if (s_axi_araddr == `CDAC_OFF_IEN)
            rdData = {30'h0, ien_r};
        else if (s_axi_araddr == `CDAC_OFF_IFS)
            rdData = '0;
        else
            rdHit = 1'b0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= `CDAC_RESP_OKAY;
        end
        else if (doRead)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdData;
            s_axi_rresp  <= rdHit ? `CDAC_RESP_OKAY : `CDAC_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule

/* src/cdac_regs.svh */
// Register offsets, field positions, reset values and timing for the current converter control
`ifndef CDAC_REGS_SVH
`define CDAC_REGS_SVH

`define CDAC_OFF_CTRL       6'h00
`define CDAC_OFF_CURPROG    6'h04
`define CDAC_OFF_DUTY       6'h0C
`define CDAC_OFF_STATUS     6'h18
`define CDAC_OFF_IF         6'h20
`define CDAC_OFF_IFS        6'h24
`define CDAC_OFF_IFC        6'h28
`define CDAC_OFF_IEN        6'h2C

`define CDAC_CTRL_EN        0
`define CDAC_CTRL_SINK      1
`define CDAC_CTRL_MINTR     2
`define CDAC_CTRL_BUSOUT    3
`define CDAC_CTRL_BSEL_LO   4
`define CDAC_CTRL_BSEL_HI   11
`define CDAC_CTRL_MASTDIS   14
`define CDAC_CTRL_BUSPRS    16
`define CDAC_CTRL_PADOUT    18
`define CDAC_CTRL_PADPRS    19
`define CDAC_CTRL_ESEL_LO   20
`define CDAC_CTRL_ESEL_HI   23
`define CDAC_CTRL_MASK      32'h00FD4FFF

`define CDAC_CUR_RANGE_LO   0
`define CDAC_CUR_RANGE_HI   1
`define CDAC_CUR_STEP_LO    8
`define CDAC_CUR_STEP_HI    12
`define CDAC_CUR_TRIM_LO    16
`define CDAC_CUR_TRIM_HI    23
`define CDAC_CUR_MASK       32'h00FF1F03
`define CDAC_CUR_RESET      32'h009B0000

`define CDAC_DUTY_MASK      32'h00000002
`define CDAC_DUTY_DIS       1
`define CDAC_FLAG_SETTLED   0
`define CDAC_FLAG_CONFLICT  1
`define CDAC_FLAG_MASK      2'h3

`define CDAC_RESP_OKAY      2'h0
`define CDAC_RESP_SLVERR    2'h2

// Settling time after enable or reprogramming, in ns
`define CDAC_SETTLE_NS      5000
`define CDAC_CLK_NS         8

`endif

/* src/cdac_pkg.sv */
// Types shared by the current converter control files
package cdac_pkg;
    typedef enum logic [1:0] {CDAC_WR_IDLE, CDAC_WR_RESP} cdac_wr_e;
    typedef logic [1:0] cdac_flags_t;
endpackage

/* src/cdac_settle_timer.sv */
// Settling timer: counts after enable or reprogramming, reports settled
`timescale 1ns/1ps
`include "cdac_regs.svh"
module cdac_settle_timer
#(
    parameter int CYCLES = 625
)
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic enable,
    input  wire logic restart,
    output logic      settled
);
    logic [$clog2(CYCLES+1)-1:0] count_r;

    // Count restarts on any change; settled only while enabled and done
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            count_r <= '0;
        else if (!enable || restart)
            count_r <= '0;
        else if (count_r != CYCLES[$clog2(CYCLES+1)-1:0])
            count_r <= count_r + 1'b1;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            settled <= 1'b0;
        else
            settled <= enable && !restart
                       && (count_r == CYCLES[$clog2(CYCLES+1)-1:0]);
    end
endmodule

/* src/cdac_event_select.sv */
// Output-enable selection between software bit and an event-network channel
`timescale 1ns/1ps
module cdac_event_select
#(
    parameter int CHANNELS = 12
)
(
    input  wire logic [CHANNELS-1:0] events,
    input  wire logic [3:0]          sel,
    input  wire logic                prsCtrl,
    input  wire logic                swEnable,
    output logic                     enable
);
    logic chan;

    // Unpopulated channel numbers read as low
    always_comb
    begin
        chan = 1'b0;
        if (32'(sel) < CHANNELS)
            chan = events[sel];
        enable = prsCtrl ? chan : swEnable;
    end
endmodule

/* sim/cdac_ctrl_monitor.sv */
// Bus handshake and bus-mastering checks bound to the converter control block
`timescale 1ns/1ps
module cdac_ctrl_monitor
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic [7:0] busSelectExternal,
    input wire logic [7:0] busChannel,
    input wire logic       busOutEnable,
    input wire logic       busMaster,
    input wire logic       busRequest
);
    // One clock domain, so clocking and reset are stated once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
    endproperty
    property p_b_release;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    // A pending response must stall new writes, or one would be lost
    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_r_release;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    property p_r_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    property p_passive;
        !busMaster |-> busChannel == busSelectExternal;
    endproperty
    property p_request;
        busRequest == (busMaster && busOutEnable);
    endproperty

    a_wr_answer: assert property (p_wr_answer) else $error("write not answered next cycle");
    a_b_release: assert property (p_b_release) else $error("write response held after taken");
    a_b_block: assert property (p_b_block) else $error("write accepted while response pending");
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
    a_r_release: assert property (p_r_release) else $error("read data held after taken");
    a_r_block: assert property (p_r_block) else $error("read address accepted while busy");
    a_passive: assert property (p_passive) else $error("passive mode ignores external select");
    a_request: assert property (p_request) else $error("bus request does not match mastering");

    c_write: cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_passive: cover property (!busMaster);
endmodule

bind cdac_ctrl cdac_ctrl_monitor cdac_ctrl_monitor_inst (.*);

/* sim/cdac_ctrl_tb.sv */
// Self-checking bench for the current converter control block
`timescale 1ns/1ps
`include "cdac_regs.svh"
module cdac_ctrl_tb;
    typedef struct packed {logic [5:0] a; logic [31:0] d, q; logic [1:0] br, rr;} cdac_row_s;
    logic        clk = 1'h0;
    logic        rstn = 1'h0;
    logic [5:0]  s_axi_awaddr = 6'h00;
    logic [5:0]  s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic [11:0] eventChannels = 12'h000;
    logic [7:0]  busSelectExternal = 8'h3A;
    logic        busRequestOther = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rangeSelect, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic [4:0]  stepSelect;
    logic [7:0]  trimValue, busChannel;
    logic        converterEnable, sinkSelect, dutyCycleDisable, busOutEnable, padOutEnable;
    logic        busMaster, busRequest, nodePrecharge, irq;
    int          fails = 0;
    int          testsRun = 0;
    int          cyc = 0;
    cdac_row_s   rows [0:7] = '{
        '{`CDAC_OFF_STATUS, 32'h3, 32'h0, `CDAC_RESP_SLVERR, `CDAC_RESP_OKAY},
        '{`CDAC_OFF_IF, 32'h3, 32'h0, `CDAC_RESP_SLVERR, `CDAC_RESP_OKAY},
        '{`CDAC_OFF_IFS, 32'h0, 32'h0, `CDAC_RESP_OKAY, `CDAC_RESP_OKAY},
        '{6'h30, 32'h0, 32'h0, `CDAC_RESP_SLVERR, `CDAC_RESP_SLVERR},
        '{`CDAC_OFF_CURPROG, 32'h00FF1F03, 32'h00FF1F03, 2'h0, 2'h0},
        '{`CDAC_OFF_DUTY, 32'h00000002, 32'h00000002, 2'h0, 2'h0},
        '{`CDAC_OFF_CTRL, 32'h00FD4FFF, 32'h00FD4FFF, 2'h0, 2'h0},
        '{`CDAC_OFF_CTRL, 32'h0, 32'h0, 2'h0, 2'h0}};
    logic [31:0] pcCtrl [0:4] = '{32'h4, 32'hC, 32'h40004, 32'h6, 32'h0};
    logic        pcExp [0:4] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0};

    cdac_ctrl #(.EVENT_CHANNELS(12), .SETTLE_CYCLES(4)) cdac_ctrl_inst (.*);

    // Free-running clock at 125 MHz
    always #4 clk = ~clk;

    // Cycle ceiling cuts a hung handshake short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Address and data offered together; each dropped at the edge that takes it
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic da;
        logic dw;
        logic t;
        logic w;
        da = 1'h0;
        dw = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(da && dw))
        begin
            @(negedge clk);
            t = s_axi_awready && !da;
            w = s_axi_wready && !dw;
            @(posedge clk);
            if (t) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            da = da | t;
            dw = dw | w;
        end
        t = 1'h0;
        while (!t)
        begin
            @(negedge clk);
            t = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk);
        end
    endtask

    task automatic rdr(input logic [5:0] a);
        logic t;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        t = 1'h0;
        while (!t)
        begin
            @(negedge clk);
            t = s_axi_arready;
            @(posedge clk);
        end
        s_axi_arvalid <= 1'h0;
        t = 1'h0;
        while (!t)
        begin
            @(negedge clk);
            t = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk);
        end
    endtask

    task automatic rchk(input logic [5:0] a, input logic [31:0] q);
        rdr(a);
        chk($sformatf("register %h", a), rd, q);
    endtask

    // Caller waits for the falling edge first: arguments are taken at the call
    task automatic look(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        chk(nm, seen, exp);
        @(posedge clk);
    endtask

    // Main sequence: reset values, register table, then the awkward cases
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        rchk(`CDAC_OFF_CURPROG, `CDAC_CUR_RESET);
        rchk(`CDAC_OFF_CTRL, 32'h0);
        chk("irq", irq, 1'h0);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            chk("write resp", rsp, rows[i].br);
            rdr(rows[i].a);
            chk("read resp", rsp, rows[i].rr);
            if (rows[i].rr == `CDAC_RESP_OKAY) chk("read data", rd, rows[i].q);
        end
        rdr(`CDAC_OFF_IFC);
        wr(`CDAC_OFF_CURPROG, 32'h00C71502);
        chk("trim", trimValue, 8'hC7);
        chk("step", stepSelect, 5'h15);
        chk("range", rangeSelect, 2'h2);
        chk("duty off", dutyCycleDisable, 1'h1);
        // Every event channel drives the bus enable; pad stays on its clear soft bit
        for (int c = 0; c < 12; c++)
        begin
            wr(`CDAC_OFF_CTRL, (32'(c) << 20) | 32'h00010000);
            eventChannels <= 12'h001 << c;
            @(negedge clk);
            look("bus enable on", busOutEnable, 1'h1);
            chk("pad enable", padOutEnable, 1'h0);
            eventChannels <= ~(12'h001 << c);
            @(negedge clk);
            look("bus enable off", busOutEnable, 1'h0);
        end
        wr(`CDAC_OFF_CTRL, 32'h00580008);
        eventChannels <= 12'h020;
        @(negedge clk);
        look("pad by event", padOutEnable, 1'h1);
        eventChannels <= 12'h000;
        @(negedge clk);
        look("pad event low", padOutEnable, 1'h0);
        chk("bus by soft bit", busOutEnable, 1'h1);
        wr(`CDAC_OFF_CTRL, 32'h00000258);
        @(negedge clk);
        look("channel", busChannel, 8'h25);
        chk("request", busRequest, 1'h1);
        wr(`CDAC_OFF_IEN, 32'h2);
        busRequestOther <= 1'h1;
        rchk(`CDAC_OFF_STATUS, 32'h2);
        rchk(`CDAC_OFF_IF, 32'h2);
        chk("irq", irq, 1'h1);
        busRequestOther <= 1'h0;
        rchk(`CDAC_OFF_STATUS, 32'h0);
        rchk(`CDAC_OFF_IF, 32'h2);
        wr(`CDAC_OFF_IEN, 32'h0);
        chk("irq masked", irq, 1'h0);
        wr(`CDAC_OFF_IFC, 32'h2);
        rchk(`CDAC_OFF_IF, 32'h0);
        wr(`CDAC_OFF_CTRL, 32'h00004258);
        @(negedge clk);
        look("passive", busMaster, 1'h0);
        chk("external channel", busChannel, 8'h3A);
        chk("no request", busRequest, 1'h0);
        // Settling: flag on the rise only, restarted by reprogramming
        wr(`CDAC_OFF_CTRL, 32'h1);
        chk("enable", converterEnable, 1'h1);
        repeat (20) @(posedge clk);
        rchk(`CDAC_OFF_STATUS, 32'h1);
        rchk(`CDAC_OFF_IF, 32'h1);
        wr(`CDAC_OFF_IFC, 32'h1);
        repeat (20) @(posedge clk);
        rchk(`CDAC_OFF_IF, 32'h0);
        wr(`CDAC_OFF_IEN, 32'h1);
        wr(`CDAC_OFF_CURPROG, 32'h009B0100);
        repeat (20) @(posedge clk);
        chk("irq settled", irq, 1'h1);
        rchk(`CDAC_OFF_IFC, 32'h1);
        rchk(`CDAC_OFF_IF, 32'h0);
        wr(`CDAC_OFF_IFS, 32'h3);
        rchk(`CDAC_OFF_IF, 32'h3);
        rchk(`CDAC_OFF_IFC, 32'h3);
        rchk(`CDAC_OFF_IF, 32'h0);
        // Node charge pauses while either soft output enable is set
        for (int i = 0; i < 5; i++)
        begin
            wr(`CDAC_OFF_CTRL, pcCtrl[i]);
            @(negedge clk);
            look("node charge", nodePrecharge, pcExp[i]);
            chk("sink", sinkSelect, pcCtrl[i][`CDAC_CTRL_SINK]);
        end
        give_verdict();
    end
endmodule
